// ### hdl/etdc_pkg.sv
// Shared constants, carriers and code-table functions for the 8b/10b codec
package etdc_pkg;

  localparam int BYTE_W = 8;
  localparam int CHAR_W = 10;
  localparam int COMMA_W = 7;
  // Positions of bits a and i inside a character, a is the MSB
  localparam int POS_A = 9;
  localparam int POS_I = 4;
  localparam logic [3:0] CHAR_LAST = 4'h9;
  // Bit slot that follows the f bit of a comma
  localparam logic [3:0] ALIGN_CNT = 4'h7;
  localparam int BAL6 = 3;
  localparam int BAL4 = 2;
  localparam int BAL10 = 5;
  localparam logic RD_INIT = 1'b0;

  localparam logic [5:0] SUB6_POS = 6'h07;
  localparam logic [5:0] SUB6_NEG = 6'h38;
  localparam logic [3:0] SUB4_POS = 4'h3;
  localparam logic [3:0] SUB4_NEG = 4'hc;
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [3:0] ALT7_4B = 4'h7;
  // Six-bit codes for the negative column, entry 0 in the low bits
  localparam logic [191:0] TAB_5B6B =
    192'hadeb8e_d969b3_e9aa8b_c938db_5dcb0d_d15979_e19a75_c6d767;
  // Four-bit codes used when the six-bit part ends negative
  localparam logic [31:0] TAB_3B4B = 32'he6adc59b;
  localparam logic [4:0] X_K28 = 5'h1c;
  localparam logic [2:0] Y_ALL = 3'h7;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] FORCE_NEG = 8'he1;
  localparam logic [7:0] FORCE_POS = 8'he2;
  localparam logic [9:0] K28_5_NEG = 10'h0fa;
  localparam logic [9:0] K28_5_POS = 10'h305;
  localparam logic [6:0] COMMA_POS = 7'h1f;
  localparam logic [6:0] COMMA_NEG = 7'h60;

  typedef struct packed {
    logic special;
    logic [BYTE_W-1:0] data;
  } etdc_tx_word_t;

  typedef struct packed {
    logic violation;
    logic special;
    logic [BYTE_W-1:0] data;
  } etdc_rx_word_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_LOCK = 2'b10
  } etdc_rx_state_t;

  // Idle filler sent while the buffer is empty
  localparam etdc_tx_word_t IDLE_WORD = '{special: 1'b1, data: K28_5};

  // Ending disparity of the abcdei sub-block
  function automatic logic sub_rd6(input logic rd, input logic [5:0] s);
    if ($countones(s) > BAL6 || s == SUB6_POS) return 1'b1;
    if ($countones(s) < BAL6 || s == SUB6_NEG) return 1'b0;
    return rd;
  endfunction

  // Ending disparity of the fghj sub-block
  function automatic logic sub_rd4(input logic rd, input logic [3:0] s);
    if ($countones(s) > BAL4 || s == SUB4_POS) return 1'b1;
    if ($countones(s) < BAL4 || s == SUB4_NEG) return 1'b0;
    return rd;
  endfunction

  // Character disparity chains through both sub-blocks
  function automatic logic char_rd(input logic rd, input logic [9:0] c);
    return sub_rd4(sub_rd6(rd, c[9:4]), c[3:0]);
  endfunction

  // Special codes that have a character of their own
  function automatic logic k_valid(input logic [7:0] b);
    logic [4:0] x;
    x = b[4:0];
    if (x == X_K28) return 1'b1;
    return (b[7:5] == Y_ALL) &&
      (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e);
  endfunction

  function automatic logic is_comma(input logic [6:0] w);
    return w == COMMA_POS || w == COMMA_NEG;
  endfunction

  // Character for a byte, taken from the column of the current disparity
  function automatic logic [9:0] encode(input logic [7:0] b, input logic k,
                                        input logic rd);
    logic [7:0] v;
    logic r;
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s6;
    logic [3:0] s4;
    logic r6;
    logic alt;
    v = b;
    r = rd;
    // Forced comma codes ignore the running disparity
    if (k && b == FORCE_NEG) begin
      v = K28_5;
      r = 1'b0;
    end
    if (k && b == FORCE_POS) begin
      v = K28_5;
      r = 1'b1;
    end
    x = v[4:0];
    y = v[7:5];
    s6 = TAB_5B6B[6*x +: 6];
    if (k && x == X_K28) s6 = K28_6B;
    if (r && ($countones(s6) != BAL6 || s6 == SUB6_NEG)) s6 = ~s6;
    r6 = sub_rd6(r, s6);
    // Alternate seven avoids a run of five equal bits
    // An unlisted special code keeps the data pattern of its byte
    alt = (y == Y_ALL) && ((k && k_valid(v)) ||
      (!r6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
      (r6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    s4 = alt ? ALT7_4B : TAB_3B4B[4*y +: 4];
    if (r6 && ($countones(s4) != BAL4 || s4 == SUB4_NEG)) s4 = ~s4;
    if (k && x == X_K28 && !r6 && $countones(s4) == BAL4 && s4 != SUB4_NEG) s4 = ~s4;
    return {s6, s4};
  endfunction

endpackage

// ### hdl/etdc_encoder.sv
// Transmit encoder: table lookup and transmit running disparity
`timescale 1ns/100ps
`default_nettype none

module etdc_encoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  input wire etdc_pkg::etdc_tx_word_t word,
  output logic [9:0] code,
  output logic rd
);

  logic rd_q;
  logic rd_d;

  // Bits abcdei come from the five-to-six table or the K28 code, fghj from the three-to-four table or the alternate seven
  always_comb begin
    code = etdc_pkg::encode(word.data, word.special, rd_q);
    rd_d = rd_q;
    if (advance) begin
      rd_d = etdc_pkg::char_rd(rd_q, code);
    end
  end

  // Either start polarity is legal, negative chosen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= etdc_pkg::RD_INIT;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd = rd_q;

endmodule

`default_nettype wire

// ### hdl/etdc_decoder.sv
// Receive decoder: column search, violation flag, receive disparity
`timescale 1ns/100ps
`default_nettype none

module etdc_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  input wire logic [9:0] code,
  output etdc_pkg::etdc_rx_word_t word,
  output logic rd
);

  logic rd_q;
  logic rd_d;
  logic hit;

  // Search only the column of the current disparity; costly but exact
  always_comb begin
    hit = 1'b0;
    word = '0;
    for (int i = 0; i < 256; i++) begin
      if (etdc_pkg::encode(8'(i), 1'b0, rd_q) == code) begin
        hit = 1'b1;
        word.data = 8'(i);
        word.special = 1'b0;
      end
      if (etdc_pkg::k_valid(8'(i)) && etdc_pkg::encode(8'(i), 1'b1, rd_q) == code) begin
        hit = 1'b1;
        word.data = 8'(i);
        word.special = 1'b1;
      end
    end
    word.violation = !hit;
    rd_d = rd_q;
    // Disparity follows the bits even for a bad character
    if (advance) begin
      rd_d = etdc_pkg::char_rd(rd_q, code);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= etdc_pkg::RD_INIT;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd = rd_q;

endmodule

`default_nettype wire

// ### hdl/etdc_codec.sv
// Codec top: transmit buffer, serializer, aligner, deserializer and checks
`timescale 1ns/100ps
`default_nettype none


module etdc_codec #(
  parameter int BUF_DEPTH = 2,
  parameter logic [2:0] LOS_LIMIT = 3'h4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire etdc_pkg::etdc_tx_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_serial,
  output logic tx_rd,
  input wire logic rx_serial_in,
  output etdc_pkg::etdc_rx_word_t rx_word,
  output logic rx_valid,
  output logic rx_aligned,
  output logic rx_rd
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] BUF_FULL = CW'(BUF_DEPTH);

  // Buffer pointer wrap, shared by both ends of the buffer
  function automatic logic [PW-1:0] nxt_ptr(input logic [PW-1:0] p);
    if (p == PW'(BUF_DEPTH - 1)) return '0;
    return p + 1'b1;
  endfunction

  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_sync_n;
  logic rx_meta_q;
  logic rx_sync_q;

  etdc_pkg::etdc_tx_word_t buf_q [BUF_DEPTH];
  etdc_pkg::etdc_tx_word_t buf_d [BUF_DEPTH];
  logic [PW-1:0] bwr_q;
  logic [PW-1:0] bwr_d;
  logic [PW-1:0] brd_q;
  logic [PW-1:0] brd_d;
  logic [CW-1:0] bcnt_q;
  logic [CW-1:0] bcnt_d;
  logic buf_push;
  logic buf_pop;
  etdc_pkg::etdc_tx_word_t head;
  logic head_forced;

  logic [3:0] tx_cnt_q;
  logic [3:0] tx_cnt_d;
  logic [9:0] tx_shift_q;
  logic [9:0] tx_shift_d;
  logic [9:0] tx_hold_q;
  logic [9:0] tx_hold_d;
  logic tx_load;
  logic [9:0] enc_code;

  logic [9:0] rx_sr_q;
  logic [9:0] rx_sr_d;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_cnt_d;
  etdc_pkg::etdc_rx_state_t st_q;
  etdc_pkg::etdc_rx_state_t st_d;
  logic [2:0] los_q;
  logic [2:0] los_d;
  logic comma_hit;
  logic char_done;
  etdc_pkg::etdc_rx_word_t dec_word;
  etdc_pkg::etdc_rx_word_t rx_word_q;
  etdc_pkg::etdc_rx_word_t rx_word_d;
  logic rx_valid_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_sync_n = rst_sync_q;

  // Serial input pin crosses in through two flops
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end else begin
      rx_meta_q <= rx_serial_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Transmit buffer handshake; drains only at character boundaries
  assign tx_ready = bcnt_q != BUF_FULL;
  assign buf_push = tx_valid && tx_ready;
  assign buf_pop = tx_load && bcnt_q != '0;
  assign head = (bcnt_q != '0) ? buf_q[brd_q] : etdc_pkg::IDLE_WORD;
  // Forced comma codes may go out against the current disparity
  assign head_forced = head.special &&
    (head.data == etdc_pkg::FORCE_NEG || head.data == etdc_pkg::FORCE_POS);

  // Buffer next state
  always_comb begin
    buf_d = buf_q;
    bwr_d = bwr_q;
    brd_d = brd_q;
    if (buf_push) begin
      buf_d[bwr_q] = tx_word;
      bwr_d = nxt_ptr(bwr_q);
    end
    if (buf_pop) begin
      brd_d = nxt_ptr(brd_q);
    end
    bcnt_d = bcnt_q + CW'(buf_push) - CW'(buf_pop);
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      buf_q <= '{default: '0};
      bwr_q <= '0;
      brd_q <= '0;
      bcnt_q <= '0;
    end else begin
      buf_q <= buf_d;
      bwr_q <= bwr_d;
      brd_q <= brd_d;
      bcnt_q <= bcnt_d;
    end
  end

  // Encoder sees the buffer head, or the idle comma when empty
  etdc_encoder u_enc (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .advance(tx_load),
    .word(head),
    .code(enc_code),
    .rd(tx_rd)
  );

  // Character divider and serializer, one bit per clock
  assign tx_load = tx_cnt_q == etdc_pkg::CHAR_LAST;

  always_comb begin
    tx_cnt_d = tx_load ? '0 : tx_cnt_q + 4'h1;
    tx_shift_d = tx_load ? enc_code : tx_shift_q << 1;
    tx_hold_d = tx_load ? enc_code : tx_hold_q;
  end

  // Divider starts at the last slot so the first character loads at once
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_cnt_q <= etdc_pkg::CHAR_LAST;
      tx_shift_q <= '0;
      tx_hold_q <= '0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      tx_shift_q <= tx_shift_d;
      tx_hold_q <= tx_hold_d;
    end
  end

  // Bit a leaves first, i sits between e and f
  assign tx_serial = tx_shift_q[etdc_pkg::POS_A];

  // Deserializer, comma aligner and loss-of-lock counter
  always_comb begin
    rx_sr_d = {rx_sr_q[etdc_pkg::CHAR_W-2:0], rx_sync_q};
    // Newest seven bits hold abcdeif when the f bit has just come in
    comma_hit = etdc_pkg::is_comma(rx_sr_d[etdc_pkg::COMMA_W-1:0]);
    rx_cnt_d = (rx_cnt_q == etdc_pkg::CHAR_LAST) ? '0 : rx_cnt_q + 4'h1;
    char_done = (st_q == etdc_pkg::RX_LOCK) && (rx_cnt_q == etdc_pkg::CHAR_LAST);
    st_d = st_q;
    los_d = los_q;
    case (st_q)
      etdc_pkg::RX_HUNT: begin
        los_d = '0;
        if (comma_hit) begin
          st_d = etdc_pkg::RX_LOCK;
        end
      end
      etdc_pkg::RX_LOCK: begin
        // A run of bad characters means the boundary is lost
        if (char_done) begin
          los_d = dec_word.violation ? los_q + 3'h1 : '0;
        end
        // A fresh comma on the last bad character only delays the return to hunt by one cycle
        if (los_d == LOS_LIMIT && !comma_hit) begin
          st_d = etdc_pkg::RX_HUNT;
          los_d = '0;
        end
      end
      default: begin
        st_d = etdc_pkg::RX_HUNT;
        los_d = '0;
      end
    endcase
    // Comma f bit just arrived: three bits remain in this character
    if (comma_hit) begin
      rx_cnt_d = etdc_pkg::ALIGN_CNT;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_sr_q <= '0;
      rx_cnt_q <= '0;
      st_q <= etdc_pkg::RX_HUNT;
      los_q <= '0;
    end else begin
      rx_sr_q <= rx_sr_d;
      rx_cnt_q <= rx_cnt_d;
      st_q <= st_d;
      los_q <= los_d;
    end
  end

  // Decoder works on the character completed this cycle
  etdc_decoder u_dec (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .advance(char_done),
    .code(rx_sr_d),
    .word(dec_word),
    .rd(rx_rd)
  );

  // Registered receive word; no stall path, the line cannot wait
  always_comb begin
    rx_word_d = char_done ? dec_word : rx_word_q;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_word_q <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_word_q <= rx_word_d;
      rx_valid_q <= char_done;
    end
  end

  assign rx_word = rx_word_q;
  assign rx_valid = rx_valid_q;
  assign rx_aligned = st_q == etdc_pkg::RX_LOCK;

  // Checks on the design's own behaviour
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!rst_sync_n);

  a_ser_bit_order: assert property (
    tx_load |=> (tx_serial == tx_hold_q[etdc_pkg::POS_A]) ##5
      (tx_serial == tx_hold_q[etdc_pkg::POS_I])
  ) else $error("serial bit order wrong");

  a_tx_column_neg: assert property (
    tx_load && !tx_rd && !head_forced |-> $countones(enc_code) >= etdc_pkg::BAL10
  ) else $error("negative column not used");

  a_tx_column_pos: assert property (
    tx_load && tx_rd && !head_forced |-> $countones(enc_code) <= etdc_pkg::BAL10
  ) else $error("positive column not used");

  a_tx_rd_flip: assert property (
    tx_load |=> tx_rd == (($countones(tx_hold_q) == etdc_pkg::BAL10) ? $past(tx_rd) :
      ($countones(tx_hold_q) > etdc_pkg::BAL10))
  ) else $error("transmit disparity update wrong");

  a_force_neg_comma: assert property (
    tx_load && head.special && head.data == etdc_pkg::FORCE_NEG |->
      enc_code == etdc_pkg::K28_5_NEG
  ) else $error("forced negative comma wrong");

  a_force_pos_comma: assert property (
    tx_load && head.special && head.data == etdc_pkg::FORCE_POS |->
      enc_code == etdc_pkg::K28_5_POS
  ) else $error("forced positive comma wrong");

  a_idle_comma: assert property (
    tx_load && bcnt_q == '0 |->
      enc_code == etdc_pkg::K28_5_NEG || enc_code == etdc_pkg::K28_5_POS
  ) else $error("idle filler is not a comma");

  a_rx_rd_track: assert property (
    char_done |=> rx_rd == etdc_pkg::char_rd($past(rx_rd), $past(rx_sr_d))
  ) else $error("receive disparity update wrong");

  a_comma_frame: assert property (
    comma_hit |-> ##3 (char_done && rx_aligned)
  ) else $error("comma did not frame character");

  a_rx_word_out: assert property (
    char_done |=> rx_valid && rx_word == $past(dec_word) ##1 !rx_valid
  ) else $error("decoded word not presented");

  c_forced_comma: cover property (
    tx_load && head.special && head.data == etdc_pkg::FORCE_NEG
  );

  c_rx_violation: cover property (rx_valid && rx_word.violation);

  c_buf_full: cover property (tx_valid && !tx_ready);

  c_rx_lock: cover property ($rose(rx_aligned));

endmodule

`default_nettype wire

// ### tb/etdc_remote.sv
// Remote transceiver model: serial source and serial capture facing the codec
`timescale 1ns/100ps
`default_nettype none

module etdc_remote (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_in,
  output logic line_out
);
  logic [20:0] send_q[$];
  logic [10:0] got_q[$];
  logic [20:0] ent;
  logic [9:0] nxt;
  logic [9:0] cur_q;
  logic [3:0] slot_q;
  logic rd_tx_q;
  logic [9:0] word_in;
  logic [9:0] sh_q;
  logic [3:0] rcnt_q;
  logic rd_rx_q;
  logic locked_q;

  // Queue one character with both columns; wrong picks the other column
  task automatic push_char(input logic [9:0] neg, input logic [9:0] pos, input logic wrong);
    send_q.push_back({wrong, pos, neg});
  endtask

  // Ending disparity, six-bit part first, then four-bit part
  function automatic logic next_rd(input logic rd, input logic [9:0] c);
    logic r;
    r = rd;
    if ($countones(c[9:4]) > 3 || c[9:4] == 6'h07) r = 1'b1;
    else if ($countones(c[9:4]) < 3 || c[9:4] == 6'h38) r = 1'b0;
    if ($countones(c[3:0]) > 2 || c[3:0] == 4'h3) r = 1'b1;
    else if ($countones(c[3:0]) < 2 || c[3:0] == 4'hc) r = 1'b0;
    return r;
  endfunction

  // Source: a bit per cycle, never idle; gaps are filled with commas
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= 4'h9;
      cur_q <= 10'h0;
      rd_tx_q <= 1'b0;
      line_out <= 1'b0;
    end else if (slot_q == 4'h9) begin
      if (send_q.size() > 0) ent = send_q.pop_front();
      else ent = {1'b0, etdc_pkg::K28_5_POS, etdc_pkg::K28_5_NEG};
      nxt = (rd_tx_q ^ ent[20]) ? ent[19:10] : ent[9:0];
      cur_q <= nxt;
      line_out <= nxt[9];
      rd_tx_q <= next_rd(rd_tx_q, nxt);
      slot_q <= 4'h0;
    end else begin
      line_out <= cur_q[4'h8 - slot_q];
      slot_q <= slot_q + 4'h1;
    end
  end

  // Capture: a comma fixes the boundary; the character ends three bits later
  assign word_in = {sh_q[8:0], line_in};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 10'h0;
      rcnt_q <= 4'h0;
      rd_rx_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      sh_q <= word_in;
      if (word_in[6:0] == etdc_pkg::COMMA_POS ||
          word_in[6:0] == etdc_pkg::COMMA_NEG) begin
        locked_q <= 1'b1;
        rcnt_q <= 4'h0;
      end else begin
        rcnt_q <= (rcnt_q == 4'h9) ? 4'h0 : rcnt_q + 4'h1;
        if (locked_q && rcnt_q == 4'h2) begin
          got_q.push_back({rd_rx_q, word_in});
          rd_rx_q <= next_rd(rd_rx_q, word_in);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/etdc_codec_tb.sv
// Self-checking testbench for the codec against the remote model
`timescale 1ns/100ps
`default_nettype none

module etdc_codec_tb;
  logic ref_clk;
  logic rst_n;
  etdc_pkg::etdc_tx_word_t tx_word;
  logic tx_valid;
  logic tx_ready;
  logic tx_serial;
  logic tx_rd;
  logic rx_line;
  etdc_pkg::etdc_rx_word_t rx_word;
  logic rx_valid;
  logic rx_aligned;
  logic rx_rd;
  int n_fail;
  int cmp_count;
  logic saw_full;
  logic [9:0] exp_q[$];
  logic [7:0] t_byte [5] = '{8'h00, 8'h07, 8'h03, 8'h60, 8'h45};
  logic [9:0] t_neg [5] = '{10'h274, 10'h38b, 10'h31b, 10'h273, 10'h295};
  logic [9:0] t_pos [5] = '{10'h18b, 10'h074, 10'h314, 10'h18c, 10'h295};

  etdc_codec #(.BUF_DEPTH(2), .LOS_LIMIT(3'h2)) etdc_codec_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_serial(tx_serial), .tx_rd(tx_rd), .rx_serial_in(rx_line),
    .rx_word(rx_word), .rx_valid(rx_valid), .rx_aligned(rx_aligned), .rx_rd(rx_rd));
  etdc_remote etdc_remote_inst (
    .clk(ref_clk), .rst_n(rst_n), .line_in(tx_serial), .line_out(rx_line));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic give_up(input string what);
    n_fail++;
    $display("BAD %s expected done seen timeout", what);
    conclude();
  endtask

  // Offer a word and hold it until taken; valid stays up for bursts
  task automatic put_word(input logic k, input logic [7:0] b);
    int n;
    n = 0;
    tx_word = '{special: k, data: b};
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) begin
      saw_full = 1'b1;
      if (n == 50) give_up("tx_ready");
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
  endtask

  // Next captured character that is not a comma, with disparity before it
  task automatic next_char(output logic [9:0] c, output logic r);
    logic [10:0] e;
    int n;
    n = 0;
    forever begin
      if (etdc_remote_inst.got_q.size() > 0) begin
        e = etdc_remote_inst.got_q.pop_front();
        c = e[9:0];
        r = e[10];
        if (c != etdc_pkg::K28_5_NEG && c != etdc_pkg::K28_5_POS) return;
      end else begin
        if (n == 400) give_up("serial character");
        @(negedge ref_clk);
        n++;
      end
    end
  endtask

  // Received words: commas are skipped, the rest must match in order
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1 && rx_word !== {2'b01, etdc_pkg::K28_5}) begin
      if (exp_q.size() == 0) check("rx unexpected", rx_word, 10'h0);
      else if (exp_q[0][9]) check("rx violation", 10'(rx_word.violation), 10'h1);
      else check("rx word", rx_word, exp_q[0]);
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  // Receive table, one wrong-column character and recovery after it
  task automatic rx_scen();
    int n;
    n = 0;
    while (rx_aligned !== 1'b1) begin
      if (n == 300) give_up("rx_aligned");
      @(negedge ref_clk);
      n++;
    end
    check("rx_aligned", 10'(rx_aligned), 10'h1);
    for (int i = 0; i < 5; i++) begin
      etdc_remote_inst.push_char(t_neg[i], t_pos[i], 1'b0);
      exp_q.push_back({2'b00, t_byte[i]});
    end
    etdc_remote_inst.push_char(t_neg[0], t_pos[0], 1'b1);
    exp_q.push_back(10'h200);
    etdc_remote_inst.push_char(t_neg[1], t_pos[1], 1'b0);
    exp_q.push_back({2'b00, t_byte[1]});
    n = 0;
    while (exp_q.size() > 0) begin
      if (n == 400) give_up("rx words");
      @(negedge ref_clk);
      n++;
    end
    check("rx pending", 10'(exp_q.size()), 10'h0);
  endtask

  // Transmit table: column picked by the disparity before each character
  task automatic tx_table();
    logic [9:0] c;
    logic r;
    for (int i = 0; i < 5; i++) begin
      put_word(1'b0, t_byte[i]);
      tx_valid = 1'b0;
      next_char(c, r);
      check("tx char", c, r ? t_pos[i] : t_neg[i]);
    end
  endtask

  // Forced comma codes twice in a row: one must land against the disparity
  task automatic tx_forced(input logic [7:0] b, input logic [9:0] want);
    logic [10:0] e;
    int hits;
    int odd;
    int n;
    hits = 0;
    odd = 0;
    n = 0;
    etdc_remote_inst.got_q.delete();
    put_word(1'b1, b);
    put_word(1'b1, b);
    tx_valid = 1'b0;
    while (etdc_remote_inst.got_q.size() < 6) begin
      if (n == 100) give_up("forced commas");
      @(negedge ref_clk);
      n++;
    end
    while (etdc_remote_inst.got_q.size() > 0) begin
      e = etdc_remote_inst.got_q.pop_front();
      if ((e[9:0] == etdc_pkg::K28_5_NEG && e[10]) || (e[9:0] == etdc_pkg::K28_5_POS && !e[10]))
        if (e[9:0] == want) hits++;
        else odd++;
    end
    check("forced comma", 10'(hits > 0), 10'h1);
    check("stray comma", 10'(odd), 10'h0);
  endtask

  // All byte values back to back; the two-entry buffer must refuse on the way
  task automatic tx_all();
    logic [9:0] c;
    logic r;
    int ones;
    saw_full = 1'b0;
    etdc_remote_inst.got_q.delete();
    for (int b = 0; b < 256; b++) put_word(1'b0, b[7:0]);
    tx_valid = 1'b0;
    check("buffer full seen", 10'(saw_full), 10'h1);
    for (int b = 0; b < 256; b++) begin
      next_char(c, r);
      ones = $countones(c);
      check("column weight",
            10'(r ? (ones == 4 || ones == 5) : (ones == 5 || ones == 6)), 10'h1);
    end
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    give_up("run");
  end

  // Main sequence
  initial begin
    n_fail = 0;
    cmp_count = 0;
    saw_full = 1'b0;
    tx_word = '0;
    tx_valid = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("reset outputs", {6'h0, tx_ready, rx_aligned, tx_rd, rx_rd}, 10'h8);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    rx_scen();
    tx_table();
    tx_forced(etdc_pkg::FORCE_NEG, etdc_pkg::K28_5_NEG);
    tx_forced(etdc_pkg::FORCE_POS, etdc_pkg::K28_5_POS);
    tx_all();
    conclude();
  end
endmodule
`default_nettype wire
